// *** hw/ep0dc_map.vh ***
// ep0dc_map.vh: constants for the endpoint-zero descriptor/config logic
// assumes: included by design files and benches by bare name
`ifndef EP0DC_MAP_VH
`define EP0DC_MAP_VH
`define EP0DC_REQ_GET_DESC   8'h06
`define EP0DC_REQ_SET_DESC   8'h07
`define EP0DC_REQ_SET_CFG    8'h09
`define EP0DC_TYPE_DEVICE    8'h01
`define EP0DC_TYPE_CONFIG    8'h02
`define EP0DC_TYPE_STRING    8'h03
`define EP0DC_TYPE_OTHER_SPD 8'h07
`define EP0DC_RT_OUT_DEV     8'h00
`define EP0DC_RT_IN_DEV      8'h80
`define EP0DC_PKT_MAX        7'h40
`define EP0DC_BUF_AW         6
`define EP0DC_DESC_AW        10
`define EP0DC_LEN_RST        16'h0000
`endif

// *** hw/ep0dc_ram.v ***
// ep0dc_ram.v: byte-wide single port memory with registered read data
// assumes: one clock, one write or read per cycle
`timescale 1ns/100ps
module ep0dc_ram
#(
   parameter AW = 6
)
(
   input  wire          i_clk_sys,
   input  wire          i_we,
   input  wire [AW-1:0] i_addr,
   input  wire [7:0]    i_wdata,
   output reg  [7:0]    o_rdata
);
   reg [7:0] mem [0:(1<<AW)-1];

   // registered read; no reset on storage to keep it a plain ram
   always @(posedge i_clk_sys)
   begin
      if (i_we)
         mem[i_addr] <= i_wdata;
      o_rdata <= mem[i_addr];
   end
endmodule

// *** hw/ep0dc_top.v ***
// ep0dc_top.v: endpoint zero descriptor and configuration request logic
// assumes: a usb packet engine delivers setup bytes, out data bytes and
// packet ends as one-cycle strobes and pulls in data bytes with i_in_rd.
// Functional notes
// - other-speed config (type 0x07) served only when high-speed capable
// - firmware loads aligned pointer; data stage served like configuration
// - firmware clears handshake nak by writing 1, then reads buffer
// - count set descriptor out bytes and compare with setup length
// - when count reaches length, answer status stage automatically
// - byte count write during a set descriptor data stage re-arms endpoint for next out packet
// - no hardware action on configuration or alternate setting change
// - pointer low write sends smaller of requested and descriptor length
`timescale 1ns/100ps
`include "ep0dc_map.vh"
module ep0dc_top
(
   input  wire        i_clk_sys,
   input  wire        i_rst,
   input  wire        i_high_speed_cap,
   input  wire        i_setup_we,
   input  wire [2:0]  i_setup_idx,
   input  wire [7:0]  i_setup_byte,
   input  wire        i_setup_done,
   input  wire        i_out_we,
   input  wire [7:0]  i_out_byte,
   input  wire        i_out_end,
   input  wire        i_fw_buf_rd,
   input  wire [5:0]  i_fw_buf_addr,
   output wire [7:0]  o_fw_buf_data,
   input  wire        i_fw_bc_wr,
   input  wire        i_fw_nak_clr,
   input  wire        i_sdp_h_wr,
   input  wire        i_sdp_l_wr,
   input  wire [7:0]  i_sdp_data,
   input  wire [7:0]  i_desc_data,
   output reg  [9:0]  o_desc_addr,
   input  wire        i_in_rd,
   output reg  [7:0]  o_in_byte,
   output wire        o_in_valid,
   output wire        o_in_pkt_end,
   output wire        o_out_ready,
   output reg         o_status_ack,
   output reg         o_handshake_nak_bit,
   output reg  [7:0]  o_cfg_req_value,
   output reg         o_stall
);
   localparam ST_IDLE = 4'b0001;
   localparam ST_LEN  = 4'b0010;
   localparam ST_SEND = 4'b0100;
   localparam ST_OUT  = 4'b1000;

   reg  [3:0]  state;
   reg  [7:0]  setup_rt;
   reg  [7:0]  setup_req;
   reg  [7:0]  setup_vh;
   reg  [15:0] setup_len;
   reg  [7:0]  sdp_hi;
   reg  [15:0] remain;
   reg  [15:0] out_count;
   reg  [5:0]  buf_wptr;
   reg  [6:0]  pkt_cnt;
   reg         out_armed;
   reg         len_phase;
   wire [15:0] next_out_count;
   wire        set_desc;
   wire        desc_type_ok;
   wire        pkt_full;
   wire [7:0]  ram_rdata;

   assign next_out_count = out_count + 16'h0001;
   assign desc_type_ok = (setup_vh == `EP0DC_TYPE_DEVICE) ||
                         (setup_vh == `EP0DC_TYPE_CONFIG) ||
                         (setup_vh == `EP0DC_TYPE_STRING);
   assign set_desc = (setup_rt == `EP0DC_RT_OUT_DEV) &&
                     (setup_req == `EP0DC_REQ_SET_DESC) && desc_type_ok;
   assign pkt_full = (pkt_cnt == `EP0DC_PKT_MAX);
   // handshake outputs are combinational from state, remain, pkt_cnt, len_phase and out_armed
   assign o_in_valid   = (state == ST_SEND) && (remain != 16'h0000) &&
                         !pkt_full && !len_phase;
   assign o_in_pkt_end = (state == ST_SEND) &&
                         (pkt_full || (remain == 16'h0000));
   assign o_out_ready  = (state == ST_OUT) && out_armed;
   assign o_fw_buf_data = ram_rdata;

   // control endpoint buffer; firmware reads it, host data fills it
   ep0dc_ram #(.AW(`EP0DC_BUF_AW)) u_buf
   (
      .i_clk_sys (i_clk_sys),
      .i_we      (i_out_we && o_out_ready),
      .i_addr    (i_out_we ? buf_wptr : i_fw_buf_addr),
      .i_wdata   (i_out_byte),
      .o_rdata   (ram_rdata)
   );

   // setup capture; configuration value is only latched for firmware,
   // hardware itself does nothing with configuration changes
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         setup_rt        <= 8'h00;
         setup_req       <= 8'h00;
         setup_vh        <= 8'h00;
         setup_len       <= `EP0DC_LEN_RST;
         o_cfg_req_value <= 8'h00;
      end
      else if (i_setup_we)
      begin
         case (i_setup_idx)
            3'h0: setup_rt <= i_setup_byte;
            3'h1: setup_req <= i_setup_byte;
            3'h2: o_cfg_req_value <= i_setup_byte;
            3'h3: setup_vh <= i_setup_byte;
            3'h6: setup_len[7:0] <= i_setup_byte;
            3'h7: setup_len[15:8] <= i_setup_byte;
            default: setup_rt <= setup_rt;
         endcase
      end
   end

   // nak bit: set on setup, cleared by firmware writing 1; set wins
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         o_handshake_nak_bit <= 1'b0;
      else if (i_setup_done)
         o_handshake_nak_bit <= 1'b1;
      else if (i_fw_nak_clr)
         o_handshake_nak_bit <= 1'b0;
   end

   // main sequencer: descriptor send and set descriptor receive
   always @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         state        <= ST_IDLE;
         sdp_hi       <= 8'h00;
         o_desc_addr  <= 10'h000;
         remain       <= 16'h0000;
         out_count    <= 16'h0000;
         buf_wptr     <= 6'h00;
         pkt_cnt      <= 7'h00;
         out_armed    <= 1'b0;
         len_phase    <= 1'b0;
         o_in_byte    <= 8'h00;
         o_status_ack <= 1'b0;
         o_stall      <= 1'b0;
      end
      else
      begin
         o_status_ack <= 1'b0;
         if (i_sdp_h_wr)
            sdp_hi <= i_sdp_data;
         if (i_setup_done)
         begin
            // a new setup aborts any transfer in flight
            state     <= ST_IDLE;
            o_stall   <= 1'b0;
            out_count <= 16'h0000;
            buf_wptr  <= 6'h00;
            out_armed <= 1'b0;
            if (set_desc)
            begin
               state     <= ST_OUT;
               out_armed <= 1'b1;
            end
            // other speed only makes sense on a high speed capable part
            if (setup_rt == `EP0DC_RT_IN_DEV &&
                setup_req == `EP0DC_REQ_GET_DESC &&
                setup_vh == `EP0DC_TYPE_OTHER_SPD && !i_high_speed_cap)
               o_stall <= 1'b1;
         end
         else
         begin
            case (state)
               ST_IDLE:
               begin
                  // aligned pointer: bit 0 forced low
                  if (i_sdp_l_wr && !o_stall)
                  begin
                     o_desc_addr <= {sdp_hi[1:0], i_sdp_data[7:1], 1'b0};
                     len_phase   <= 1'b1;
                     state       <= ST_LEN;
                  end
               end
               ST_LEN:
               begin
                  // address set last cycle; wait one cycle, then take the length byte
                  if (len_phase)
                     len_phase <= 1'b0;
                  else
                  begin
                     remain <= ({8'h00, i_desc_data} < setup_len) ?
                               {8'h00, i_desc_data} : setup_len;
                     o_in_byte <= i_desc_data;
                     pkt_cnt   <= 7'h00;
                     state     <= ST_SEND;
                  end
               end
               ST_SEND:
               begin
                  // packetised at max packet size
                  if (o_in_valid && i_in_rd)
                  begin
                     remain      <= remain - 16'h0001;
                     pkt_cnt     <= pkt_cnt + 7'h01;
                     o_desc_addr <= o_desc_addr + 10'h001;
                     len_phase   <= 1'b1;
                  end
                  else if (len_phase)
                  begin
                     len_phase <= 1'b0;
                     o_in_byte <= i_desc_data;
                  end
                  if (o_in_pkt_end && i_in_rd)
                  begin
                     pkt_cnt <= 7'h00;
                     if (remain == 16'h0000)
                     begin
                        o_status_ack <= 1'b1;
                        state        <= ST_IDLE;
                     end
                  end
               end
               ST_OUT:
               begin
                  // count host bytes and compare with setup length
                  if (i_out_we && out_armed)
                  begin
                     out_count <= next_out_count;
                     buf_wptr  <= buf_wptr + 6'h01;
                  end
                  if (i_out_end && out_armed)
                     out_armed <= 1'b0;       // wait for firmware
                  if (i_fw_bc_wr)
                  begin
                     out_armed <= 1'b1;
                     buf_wptr  <= 6'h00;
                  end
                  if (out_count == setup_len && !out_armed &&
                      !o_handshake_nak_bit)
                  begin
                     o_status_ack <= 1'b1;
                     state        <= ST_IDLE;
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end
endmodule

// *** test/ep0dc_host.sv ***
// ep0dc_host.sv: host side, pulls in data bytes and packet ends
// assumes: strobes are taken at the rising edge they are seen high
`timescale 1ns/100ps
module ep0dc_host
(
   input  wire        i_clk_sys,
   input  wire        i_slow,
   input  wire        i_clr,
   input  wire        i_in_valid,
   input  wire        i_in_pkt_end,
   input  wire [7:0]  i_in_byte,
   output reg         o_in_rd = 1'h0,
   output reg  [15:0] o_n_byte = 16'h0000,
   output reg  [7:0]  o_x_byte = 8'h00
);
   reg [1:0] cnt = 2'h0;
   // one take at a time; slow mode only takes every fourth cycle
   always @(posedge i_clk_sys)
   begin
      cnt <= cnt + 2'h1;
      o_in_rd <= (i_in_valid | i_in_pkt_end) & !o_in_rd & (!i_slow | &cnt);
      if (i_clr)
         {o_n_byte, o_x_byte} <= 24'h000000;
      else if (o_in_rd & i_in_valid)
         {o_n_byte, o_x_byte} <= {o_n_byte + 16'h1, o_x_byte ^ i_in_byte};
   end
endmodule

// *** test/ep0dc_props.sv ***
// ep0dc_props.sv: port checks bound into ep0dc_top
// assumes: one clock, async active-high reset
`timescale 1ns/100ps
module ep0dc_props
(
   input wire i_clk_sys,
   input wire i_rst,
   input wire i_setup_done,
   input wire i_fw_nak_clr,
   input wire i_out_end,
   input wire i_fw_bc_wr,
   input wire i_in_rd,
   input wire o_in_valid,
   input wire o_out_ready,
   input wire o_status_ack,
   input wire o_handshake_nak_bit,
   input wire o_stall
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   // nak gates the set descriptor status stage, so it may drop only on a firmware clear
   chk_nak_set: assert property
      (i_setup_done |=> o_handshake_nak_bit) else $error("nak not set");
   chk_nak_hold: assert property
      (o_handshake_nak_bit && !i_fw_nak_clr |=> o_handshake_nak_bit)
      else $error("nak dropped");
   chk_nak_clr: assert property
      (i_fw_nak_clr && !i_setup_done |=> !o_handshake_nak_bit)
      else $error("nak not cleared");
   chk_ack_once: assert property
      (o_status_ack |=> !o_status_ack) else $error("ack too long");
   chk_ack_cond: assert property
      (o_status_ack |-> !o_handshake_nak_bit && !o_out_ready)
      else $error("ack while pending");
   chk_end_disarm: assert property
      (i_out_end && !i_fw_bc_wr |=> !o_out_ready) else $error("still armed");
   chk_stall_quiet: assert property
      (o_stall |-> !o_in_valid) else $error("data while stalled");
   chk_in_step: assert property
      (i_in_rd && o_in_valid |=> !o_in_valid) else $error("byte not taken");
endmodule
bind ep0dc_top ep0dc_props u_props (.i_clk_sys, .i_rst, .i_setup_done,
   .i_fw_nak_clr, .i_out_end, .i_fw_bc_wr, .i_in_rd, .o_in_valid,
   .o_out_ready, .o_status_ack, .o_handshake_nak_bit, .o_stall);

// *** test/tb.sv ***
// tb.sv: self-checking bench for ep0dc_top
// assumes: ep0dc_host takes in data; descriptor memory modelled here
`timescale 1ns/100ps
`include "ep0dc_map.vh"
module tb;
   reg         i_clk_sys = 1'h0;
   reg         i_rst = 1'h1;
   reg         hs = 1'h1, swe = 1'h0, sdone = 1'h0, owe = 1'h0, oend = 1'h0;
   reg         frd = 1'h0, bcw = 1'h0, nclr = 1'h0, sph = 1'h0, spl = 1'h0;
   reg         slow = 1'h0, hclr = 1'h0;
   reg  [2:0]  sidx = 3'h0;
   reg  [7:0]  sb = 8'h00, ob = 8'h00, sd = 8'h00, dl = 8'h00;
   reg  [9:0]  ptr = 10'h000;
   reg  [31:0] rs = 32'h26, cyc = 32'h0, nack = 32'h0;
   integer     n_fail = 0, tests_run = 0, t;
   wire [7:0]  fdat, ib, cfg, ddat, hx;
   wire [9:0]  da;
   wire [15:0] hn;
   wire        iv, ipe, rdy, ack, nak, stl, ird;
   // first byte at the pointer is the descriptor length
   assign ddat = (da == ptr) ? dl : da[7:0];
   ep0dc_top dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_high_speed_cap(hs), .i_setup_we(swe), .i_setup_idx(sidx),
      .i_setup_byte(sb), .i_setup_done(sdone), .i_out_we(owe),
      .i_out_byte(ob), .i_out_end(oend), .i_fw_buf_rd(frd),
      .i_fw_buf_addr(6'h00), .o_fw_buf_data(fdat), .i_fw_bc_wr(bcw),
      .i_fw_nak_clr(nclr), .i_sdp_h_wr(sph), .i_sdp_l_wr(spl),
      .i_sdp_data(sd), .i_desc_data(ddat), .o_desc_addr(da),
      .i_in_rd(ird), .o_in_byte(ib), .o_in_valid(iv),
      .o_in_pkt_end(ipe), .o_out_ready(rdy), .o_status_ack(ack),
      .o_handshake_nak_bit(nak), .o_cfg_req_value(cfg), .o_stall(stl));
   ep0dc_host host (.i_clk_sys(i_clk_sys), .i_slow(slow), .i_clr(hclr),
      .i_in_valid(iv), .i_in_pkt_end(ipe), .i_in_byte(ib),
      .o_in_rd(ird), .o_n_byte(hn), .o_x_byte(hx));
   always #50 i_clk_sys = ~i_clk_sys;
   // acks are counted so a missing or doubled one shows up
   always @(posedge i_clk_sys)
   begin
      cyc <= cyc + 32'h1;
      nack <= nack + {31'h0, ack};
      if (cyc == 32'd40000)
      begin
         n_fail = n_fail + 1;
         complete_run;
      end
   end
   function [31:0] xs(input [31:0] s);
      reg [31:0] v;
   begin
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
   end
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         n_fail = n_fail + 1;
         $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
      end
   end
   endtask
   task complete_run;
   begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   end
   endtask
   // eight setup bytes, the done strobe, then a clear of the host tally
   task setup(input [63:0] s);
      integer k;
   begin
      for (k = 0; k < 8; k = k + 1)
      begin
         @(posedge i_clk_sys);
         swe <= 1'h1;
         sidx <= k[2:0];
         sb <= s[8*k +: 8];
      end
      @(posedge i_clk_sys);
      swe <= 1'h0;
      sdone <= 1'h1;
      @(posedge i_clk_sys);
      sdone <= 1'h0;
      hclr <= 1'h1;
      @(posedge i_clk_sys);
      hclr <= 1'h0;
   end
   endtask
   task get(input [7:0] ty, input [15:0] ln, input [7:0] len_d);
      integer k, n, a;
      reg [7:0] x;
      reg e;
   begin
      rs = xs(rs);
      ptr <= {rs[9:1], 1'h0};
      dl <= len_d;
      slow <= rs[12];
      setup({ln, 16'h0000, ty, 8'h00, `EP0DC_REQ_GET_DESC, `EP0DC_RT_IN_DEV});
      // expectations use hs and ptr only once their updates have landed
      e = (ty == `EP0DC_TYPE_OTHER_SPD) && !hs;
      n = e ? 0 : (ln < len_d) ? ln : len_d;
      x = 8'h00;
      for (k = 0; k < n; k = k + 1)
         x = x ^ ((k == 0) ? len_d : ptr[7:0] + k[7:0]);
      a = nack;
      sph <= 1'h1;
      sd <= {6'h00, ptr[9:8]};
      @(posedge i_clk_sys);
      sph <= 1'h0;
      spl <= 1'h1;
      sd <= ptr[7:0];
      @(posedge i_clk_sys);
      spl <= 1'h0;
      nclr <= 1'h1;
      @(posedge i_clk_sys);
      nclr <= 1'h0;
      for (k = 0; k < 1500 && nack == a; k = k + 1)
         @(posedge i_clk_sys);
      chk(stl, e);
      chk(hn, n);
      chk(hx, x);
      chk(nack - a, !e);
   end
   endtask
   task sdesc(input [7:0] ty, input [15:0] ln);
      integer k, p, a;
      reg [7:0] v, b0;
   begin
      rs = xs(rs);
      v = rs[7:0];
      setup({ln, 16'h0000, ty, v, `EP0DC_REQ_SET_DESC, `EP0DC_RT_OUT_DEV});
      chk(cfg, v);
      a = nack;
      nclr <= 1'h1;
      for (p = 0; p < ln; p = p + 64)
      begin
         for (k = 0; k < 50 && (k == 0 || rdy !== 1'h1); k = k + 1)
            @(negedge i_clk_sys);
         chk(rdy, 1);
         for (k = p; k < ln && k < p + 64; k = k + 1)
         begin
            @(posedge i_clk_sys);
            nclr <= 1'h0;
            rs = xs(rs);
            if (k == p)
               b0 = rs[7:0];
            owe <= 1'h1;
            ob <= rs[7:0];
         end
         @(posedge i_clk_sys);
         owe <= 1'h0;
         oend <= 1'h1;
         @(posedge i_clk_sys);
         oend <= 1'h0;
         frd <= 1'h1;
         @(posedge i_clk_sys);
         frd <= 1'h0;
         repeat (3) @(posedge i_clk_sys);
         chk(fdat, b0);
         chk(nack - a, p + 64 >= ln);
         bcw <= 1'h1;
         @(posedge i_clk_sys);
         bcw <= 1'h0;
      end
   end
   endtask
   initial
   begin
      repeat (4) @(posedge i_clk_sys);
      i_rst <= 1'h0;
      // outputs stay at their reset values for the first edges after release
      repeat (2)
      begin
         @(negedge i_clk_sys);
         chk({stl, nak, ack, iv, ipe, rdy, cfg, ib, da}, 0);
      end
      get(`EP0DC_TYPE_CONFIG, 16'h0080, 8'hC8);
      get(`EP0DC_TYPE_STRING, 16'h0001, 8'h20);
      for (t = 0; t < 4; t = t + 1)
      begin
         rs = xs(rs);
         get(`EP0DC_TYPE_CONFIG, {8'h00, rs[23:16] | 8'h01}, rs[7:0] | 8'h01);
      end
      hs <= 1'h0;
      get(`EP0DC_TYPE_OTHER_SPD, 16'h0010, 8'h09);
      hs <= 1'h1;
      get(`EP0DC_TYPE_OTHER_SPD, 16'h0010, 8'h09);
      sdesc(`EP0DC_TYPE_DEVICE, 16'h0001);
      sdesc(`EP0DC_TYPE_CONFIG, 16'h0040);
      sdesc(`EP0DC_TYPE_STRING, 16'h0082);
      setup({32'h0, 8'h00, 8'h05, `EP0DC_REQ_SET_CFG, `EP0DC_RT_OUT_DEV});
      t = nack;
      // firmware re-arms its endpoints; the block must not react to it
      bcw <= 1'h1;
      @(posedge i_clk_sys);
      bcw <= 1'h0;
      repeat (20) @(posedge i_clk_sys);
      chk(cfg, 8'h05);
      chk({stl, nak, rdy}, 3'h2);
      chk(nack - t, 0);
      nclr <= 1'h1;
      @(posedge i_clk_sys);
      nclr <= 1'h0;
      repeat (2) @(posedge i_clk_sys);
      chk(nak, 0);
      // host follows with a set interface; still no hardware action
      setup({32'h0, 8'h00, 8'h01, 8'h0B, `EP0DC_RT_OUT_DEV});
      repeat (4) @(posedge i_clk_sys);
      chk(cfg, 8'h01);
      chk({stl, nak, rdy, iv}, 4'h4);
      chk(nack - t, 0);
      complete_run;
   end
endmodule
